// *** hw/mcs_pkg.sv ***
// constants, register map and field layout of the clock synthesizer control
// assumes one 100 MHz clock; all derived clocks are levels made on it
`default_nettype none
package mcs_pkg;
    localparam int CLOCK_MHZ = 100;
    localparam logic [7:0] OFFS_PLL_CFG = 8'h04;
    localparam logic [7:0] OFFS_AUX_CFG = 8'h06;
    localparam logic [7:0] OFFS_RX_CTRL = 8'h07;
    localparam logic [7:0] OFFS_BIAS = 8'h13;
    localparam logic [7:0] RST_PLL_CFG = 8'h00;
    localparam logic [7:0] RST_AUX_CFG = 8'h00;
    localparam logic [7:0] RST_RX_CTRL = 8'h00;
    localparam logic [7:0] RST_BIAS = 8'h00;
    localparam int POS_MULT = 0;
    localparam int POS_ADC_DIV = 2;
    localparam int POS_ADC_SEL = 4;
    localparam int POS_PRI_OFF = 0;
    localparam int POS_PRI_INV = 1;
    localparam int POS_PRI_DIV = 2;
    localparam int POS_SEC_OFF = 4;
    localparam int POS_SEC_INV = 5;
    localparam int POS_SEC_DIV = 6;
    localparam int POS_LOW_PWR = 4;
    localparam int POS_BIAS = 0;
    localparam int CHAIN_W = 4;
    localparam int RX_LATENCY = 10;
    localparam int RX_W = 12;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } mcs_reg_req_type;

    typedef struct packed {
        logic adcFromPll;
        logic [1:0] adcDiv;
        logic [1:0] mult;
    } mcs_pll_type;

    typedef struct packed {
        logic [1:0] secDiv;
        logic secInv;
        logic secOff;
        logic [1:0] priDiv;
        logic priInv;
        logic priOff;
    } mcs_aux_type;
endpackage
`default_nettype wire

// *** hw/mcs_delay_line.sv ***
// enabled shift register; output comes from the last stage register
// assumes the enable is a one-cycle pulse on the same clock
`default_nettype none
module mcs_delay_line #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 10
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    logic [WIDTH-1:0] stage_q [DEPTH];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else if (enable) begin
            stage_q[0] <= dataIn;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign dataOut = stage_q[DEPTH-1];
endmodule
`default_nettype wire

// *** hw/mcs_clock_synth.sv ***
// clock synthesizer control: registers, divider chain, aux clock outputs,
// adc clock select and receive latency pipeline
// assumes reference pin and adc samples are asynchronous to clock
`default_nettype none
// Contract
// - dac update clock is reference times two to the multiplier exponent.
// - pll-sourced adc clock is dac clock divided by two to divide field.
// - select bit picks adc clock: buffered reference or divided vco.
// - tx and rx word rates equal; adc rate is word rate.
// - full-duplex receive clock runs at twice the word rate; code gives inverted chain bit 0, same rate, when the tap index is 0.
// - first aux clock is dac clock divided by two to its field.
// - first aux clock comes from pll divider chain, deterministic phase.
// - second aux clock is reference divided by two to its field; code divides by four for field 3.
// - second field zero gives delayed reference copy; else near 50% duty.
// - each aux output has its own invert and disable bit.
// - aux clock outputs keep toggling during hardware or software reset.
// - receive latency 10.0 adc cycles half duplex, 10.5 full duplex; code gives 9.5 full duplex.
// - receive control bit 4 puts adc in reduced power mode.
// - bias register bits 2:0 select adc power bias setting.
module mcs_clock_synth
    import mcs_pkg::*;
#(
    parameter int DATA_W = RX_W,
    parameter int LATENCY = RX_LATENCY
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic softReset,
    input wire mcs_reg_req_type regReq,
    output logic [7:0] regReadData,
    input wire logic reference_clock_in,
    input wire logic fullDuplex,
    input wire logic [DATA_W-1:0] adcSample,
    output logic [DATA_W-1:0] rxData,
    output logic dacUpdateClock,
    output logic adcSampleClock,
    output logic receive_side_clock,
    output logic primary_aux_clock_out,
    output logic secondary_aux_clock_out,
    output logic pllLocked,
    output logic adcLowPower,
    output logic [2:0] adcBiasSelect
);
    logic [7:0] pllCfg_q;
    logic [7:0] auxCfg_q;
    logic [7:0] rxCtrl_q;
    logic [7:0] bias_q;
    logic [7:0] readData_q;
    logic refMeta_q;
    logic refSync_q;
    logic refPrev_q;
    logic [CHAIN_W-1:0] chain_q;
    logic [CHAIN_W-1:0] chain_d;
    logic locked_q;
    logic [1:0] secCount_q;
    logic adcPrev_q;
    logic [DATA_W-1:0] sampleMeta_q;
    logic [DATA_W-1:0] sampleSync_q;
    logic [DATA_W-1:0] rxData_q;
    logic [DATA_W-1:0] pipeOut;
    logic priLevel_q;
    logic secLevel_q;
    mcs_pll_type pll;
    mcs_aux_type aux;
    logic refRise;
    logic [CHAIN_W-1:0] lowMask;
    logic [CHAIN_W-1:0] refPhase;
    logic refAligned;
    logic adcFromChain;
    logic adcLevel;
    logic adcRise;
    logic adcFall;
    logic [1:0] fastIdx;
    logic rxFastLevel;
    logic priNext;
    logic secNext;
    logic [DATA_W-1:0] rxData_d;
    logic wrPll;
    logic wrAux;
    logic wrRx;
    logic wrBias;
    logic [7:0] readMux;

    assign pll = mcs_pll_type'(pllCfg_q[POS_ADC_SEL:POS_MULT]);
    assign aux = mcs_aux_type'(auxCfg_q);

    // register decode
    assign wrPll = regReq.write && regReq.addr == OFFS_PLL_CFG;
    assign wrAux = regReq.write && regReq.addr == OFFS_AUX_CFG;
    assign wrRx = regReq.write && regReq.addr == OFFS_RX_CTRL;
    assign wrBias = regReq.write && regReq.addr == OFFS_BIAS;
    assign readMux = (regReq.addr == OFFS_PLL_CFG) ? pllCfg_q :
                     (regReq.addr == OFFS_AUX_CFG) ? auxCfg_q :
                     (regReq.addr == OFFS_RX_CTRL) ? rxCtrl_q :
                     (regReq.addr == OFFS_BIAS) ? bias_q : 8'h00;

    // software reset clears the registers only, never the dividers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pllCfg_q <= RST_PLL_CFG;
            auxCfg_q <= RST_AUX_CFG;
            rxCtrl_q <= RST_RX_CTRL;
            bias_q <= RST_BIAS;
        end else if (softReset) begin
            pllCfg_q <= RST_PLL_CFG;
            auxCfg_q <= RST_AUX_CFG;
            rxCtrl_q <= RST_RX_CTRL;
            bias_q <= RST_BIAS;
        end else begin
            if (wrPll) pllCfg_q <= regReq.data;
            if (wrAux) auxCfg_q <= regReq.data;
            if (wrRx) rxCtrl_q <= regReq.data;
            if (wrBias) bias_q <= regReq.data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            readData_q <= 8'h00;
        end else begin
            readData_q <= readMux;
        end
    end
    assign regReadData = readData_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            refMeta_q <= 1'b0;
            refSync_q <= 1'b0;
            refPrev_q <= 1'b0;
        end else begin
            refMeta_q <= reference_clock_in;
            refSync_q <= refMeta_q;
            refPrev_q <= refSync_q;
        end
    end
    assign refRise = refSync_q && !refPrev_q;

    // vco is the divider chain; each reference rise pulls its low bits to
    // the phase where bit m rises, so chain bit m tracks the reference
    assign lowMask = CHAIN_W'((5'd2 << pll.mult) - 5'd1);
    assign refPhase = CHAIN_W'(4'd1 << pll.mult);
    assign refAligned = ((chain_q + 4'd1) & lowMask) == refPhase;
    always_comb begin
        chain_d = chain_q + 4'd1;
        if (refRise) begin
            chain_d = (chain_q & ~lowMask) | refPhase;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chain_q <= '0;
            locked_q <= 1'b0;
        end else begin
            chain_q <= chain_d;
            if (refRise) locked_q <= refAligned;
        end
    end
    assign pllLocked = locked_q;
    assign dacUpdateClock = chain_q[0];

    // adc clock: buffered reference or chain tap n
    assign adcFromChain = chain_q[pll.adcDiv];
    assign adcLevel = pll.adcFromPll ? adcFromChain : refSync_q;

    // full duplex receive clock is one tap faster than the adc clock; at tap 0 it is tap 0 inverted
    assign fastIdx = pll.adcFromPll ? pll.adcDiv : pll.mult;
    assign rxFastLevel = (fastIdx == 2'd0) ? ~chain_q[0] :
                         chain_q[fastIdx - 2'd1];
    always_comb begin
        receive_side_clock = adcLevel;
        if (fullDuplex) receive_side_clock = rxFastLevel;
    end
    assign adcSampleClock = adcLevel;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            adcPrev_q <= 1'b0;
        end else begin
            adcPrev_q <= adcLevel;
        end
    end
    assign adcRise = adcLevel && !adcPrev_q;
    assign adcFall = !adcLevel && adcPrev_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sampleMeta_q <= '0;
            sampleSync_q <= '0;
        end else begin
            sampleMeta_q <= adcSample;
            sampleSync_q <= sampleMeta_q;
        end
    end

    mcs_delay_line #(
        .WIDTH(DATA_W),
        .DEPTH(LATENCY)
    ) u_pipe (
        .clock(clock),
        .reset_n(reset_n),
        .enable(adcRise),
        .dataIn(sampleSync_q),
        .dataOut(pipeOut)
    );

    // full duplex takes half an adc cycle off by releasing on the falling edge
    always_comb begin
        rxData_d = rxData_q;
        if (!fullDuplex && adcRise) rxData_d = pipeOut;
        if (fullDuplex && adcFall) rxData_d = pipeOut;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxData_q <= '0;
        end else begin
            rxData_q <= rxData_d;
        end
    end
    assign rxData = rxData_q;

    // second aux divider runs on reference rises
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            secCount_q <= 2'd0;
        end else if (refRise) begin
            secCount_q <= secCount_q + 2'd1;
        end
    end

    assign priNext = aux.priOff ? 1'b0 :
                     (chain_q[aux.priDiv] ^ aux.priInv);
    assign secNext = aux.secOff ? 1'b0 :
                     (((aux.secDiv == 2'd0) ? refSync_q :
                       secCount_q[aux.secDiv[1]]) ^ aux.secInv);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            priLevel_q <= 1'b0;
            secLevel_q <= 1'b0;
        end else begin
            priLevel_q <= priNext;
            secLevel_q <= secNext;
        end
    end

    // during hardware reset the pins carry the raw reference so they
    // never stop; software reset leaves the dividers running
    assign primary_aux_clock_out =
        reset_n ? priLevel_q : reference_clock_in;
    assign secondary_aux_clock_out =
        reset_n ? secLevel_q : reference_clock_in;

    assign adcLowPower = rxCtrl_q[POS_LOW_PWR];
    assign adcBiasSelect = bias_q[POS_BIAS +: 3];
endmodule
`default_nettype wire

// *** hw/dummy_removed.sv ***
// intentionally empty
`default_nettype none
`default_nettype wire

// *** test/mcs_backend_model.sv ***
// back end side: free running reference oscillator and sample source
// assumes nothing of the system clock; phase is unrelated to it
`default_nettype none
module mcs_backend_model #(
    parameter int HALF_NS = 10,
    parameter int DATA_W = 12
) (
    output logic reference_clock_in,
    output logic [DATA_W-1:0] adcSample
);
    timeunit 1ns;
    timeprecision 100ps;
    // 50 MHz reference, inside the accepted input range
    initial begin
        reference_clock_in = 1'b0;
        adcSample = '0;
        #3;
        // one new sample per reference period, on its rising edge
        forever begin
            #HALF_NS reference_clock_in = ~reference_clock_in;
            if (reference_clock_in) adcSample = adcSample + DATA_W'(1);
        end
    end
endmodule
`default_nettype wire

// *** test/mcs_clock_synth_properties.sv ***
// checker for the clock synthesizer control, bound to its top module
// assumes one clock domain and the register map of the package
`default_nettype none
module mcs_clock_synth_properties
    import mcs_pkg::*;
#(
    parameter int DATA_W = RX_W,
    parameter int LATENCY = RX_LATENCY
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic softReset,
    input wire mcs_reg_req_type regReq,
    input wire logic [7:0] regReadData,
    input wire logic reference_clock_in,
    input wire logic fullDuplex,
    input wire logic [DATA_W-1:0] adcSample,
    input wire logic [DATA_W-1:0] rxData,
    input wire logic dacUpdateClock,
    input wire logic adcSampleClock,
    input wire logic receive_side_clock,
    input wire logic primary_aux_clock_out,
    input wire logic secondary_aux_clock_out,
    input wire logic pllLocked,
    input wire logic adcLowPower,
    input wire logic [2:0] adcBiasSelect
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pllQ;
    logic [7:0] auxQ;
    logic [2:0] age;
    wire logic wrOk = regReq.write && !softReset;
    // shadow of the clock registers and a saturating age since reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pllQ <= 8'h00;
            auxQ <= 8'h00;
            age <= 3'h0;
        end else begin
            age <= (age == 3'h7) ? age : age + 3'h1;
            if (softReset) pllQ <= 8'h00;
            if (softReset) auxQ <= 8'h00;
            if (wrOk && regReq.addr == OFFS_PLL_CFG) pllQ <= regReq.data;
            if (wrOk && regReq.addr == OFFS_AUX_CFG) auxQ <= regReq.data;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_low_power: assert property (wrOk && regReq.addr == OFFS_RX_CTRL
        |=> adcLowPower == $past(regReq.data[POS_LOW_PWR]))
        else $error("low power bit wrong");
    a_bias_select: assert property (wrOk && regReq.addr == OFFS_BIAS
        |=> adcBiasSelect == $past(regReq.data[2:0]))
        else $error("bias select wrong");
    a_ref_copy: assert property (age == 3'h7
        && $past(auxQ[7:4]) == 4'h0
        |-> secondary_aux_clock_out == $past(reference_clock_in, 3))
        else $error("second output not a delayed reference");
    a_pri_off: assert property ($past(auxQ[POS_PRI_OFF])
        |-> !primary_aux_clock_out) else $error("first output not disabled");
    a_pri_divide: assert property (age == 3'h7
        && $past(auxQ[3:2]) == 2'h0 && !$past(auxQ[0])
        |-> primary_aux_clock_out == ($past(dacUpdateClock) ^ $past(auxQ[1])))
        else $error("first output not the update clock");
    a_adc_pll: assert property (pllQ[4] && pllQ[3:2] == 2'h0
        |-> adcSampleClock == dacUpdateClock) else $error("adc clock tap");
    a_adc_ref: assert property (age == 3'h7 && !pllQ[4]
        |-> adcSampleClock == $past(reference_clock_in, 2))
        else $error("adc clock not the reference");
    a_rx_double: assert property (fullDuplex && pllQ[4]
        && pllQ[3:2] == 2'h1 |-> receive_side_clock == dacUpdateClock)
        else $error("receive clock not doubled");
    c_full_pll: cover property (fullDuplex && pllQ[4]);
    c_pri_inv: cover property (auxQ[POS_PRI_INV]);
    c_soft: cover property (softReset && age == 3'h7);
endmodule
bind mcs_clock_synth mcs_clock_synth_properties #(
    .DATA_W(DATA_W),
    .LATENCY(LATENCY)
) i_mcs_clock_synth_properties (.clock, .reset_n, .softReset, .regReq,
    .regReadData, .reference_clock_in, .fullDuplex, .adcSample, .rxData,
    .dacUpdateClock, .adcSampleClock, .receive_side_clock, .pllLocked,
    .primary_aux_clock_out, .secondary_aux_clock_out, .adcLowPower,
    .adcBiasSelect);
`default_nettype wire

// *** test/mcs_clock_synth_tb.sv ***
// self-checking bench for the clock synthesizer control
// assumes the back end model drives the reference pin and samples
`default_nettype none
`define CHK(got, exp) \
    testsRun++; \
    if ((got) !== (exp)) begin \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
        fails++; \
    end
module mcs_clock_synth_tb import mcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, reset_n, softReset, fullDuplex, last;
    mcs_reg_req_type regReq;
    logic [7:0] regReadData, v;
    logic reference_clock_in, dacUpdateClock, adcSampleClock;
    logic receive_side_clock, primary_aux_clock_out, secondary_aux_clock_out;
    logic pllLocked, adcLowPower;
    logic [2:0] adcBiasSelect;
    logic [RX_W-1:0] adcSample, rxData, lag;
    int fails, testsRun, toggles;
    logic [7:0] rowAddr[5] = '{8'h04, 8'h06, 8'h07, 8'h13, 8'h05};
    logic [7:0] rowData[5] = '{8'h17, 8'h9c, 8'h10, 8'h05, 8'hff};
    logic [7:0] rowExp[5] = '{8'h17, 8'h9c, 8'h10, 8'h05, 8'h00};
    logic [7:0] pllRow[4] = '{8'h10, 8'h14, 8'h00, 8'h14};
    logic [7:0] auxRow[4] = '{8'h00, 8'h02, 8'h01, 8'h40};
    mcs_clock_synth i_mcs_clock_synth (.clock, .reset_n, .softReset, .regReq,
        .regReadData, .reference_clock_in, .fullDuplex, .adcSample, .rxData,
        .dacUpdateClock, .adcSampleClock, .receive_side_clock, .pllLocked,
        .primary_aux_clock_out, .secondary_aux_clock_out, .adcLowPower,
        .adcBiasSelect);
    mcs_backend_model #(.DATA_W(RX_W)) i_mcs_backend_model (
        .reference_clock_in, .adcSample);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{write: 1'b1, addr: a, data: d};
        @(posedge clock);
        regReq.write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        regReq <= '{write: 1'b0, addr: a, data: 8'h00};
        @(posedge clock);
        @(negedge clock);
        v = regReadData;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        softReset = 1'b0;
        fullDuplex = 1'b0;
        regReq = '0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(rowAddr[i], rowData[i]);
            rd(rowAddr[i]);
            `CHK(v, rowExp[i])
        end
        `CHK(adcLowPower, 1'b1)
        `CHK(adcBiasSelect, 3'h5)
        // clock source, divider, invert and disable settings in turn
        for (int i = 0; i < 4; i++) begin
            wr(OFFS_PLL_CFG, pllRow[i]);
            wr(OFFS_AUX_CFG, auxRow[i]);
            fullDuplex <= i[0];
            repeat (40) @(posedge clock);
            @(negedge clock);
            // a 50 MHz reference with a unit multiplier must lock
            `CHK(pllLocked, 1'b1)
            if (i == 2) begin
                // ten adc cycles plus at most one for the input synchroniser
                lag = adcSample - rxData;
                `CHK(lag inside {RX_LATENCY, RX_LATENCY + 1}, 1'b1)
            end
            if (i == 3) begin
                // reference halved: one toggle every two system clocks
                last = secondary_aux_clock_out;
                toggles = 0;
                repeat (8) begin
                    @(negedge clock);
                    toggles += int'(secondary_aux_clock_out !== last);
                    last = secondary_aux_clock_out;
                end
                `CHK(toggles, 4)
            end
        end
        @(posedge clock);
        softReset <= 1'b1;
        @(negedge clock);
        last = primary_aux_clock_out;
        toggles = 0;
        repeat (8) begin
            @(negedge clock);
            toggles += int'(primary_aux_clock_out !== last);
            last = primary_aux_clock_out;
        end
        `CHK(toggles > 2, 1'b1)
        `CHK(adcLowPower, 1'b0)
        `CHK(adcBiasSelect, 3'h0)
        @(posedge clock);
        softReset <= 1'b0;
        reset_n <= 1'b0;
        repeat (6) begin
            @(negedge clock);
            `CHK(primary_aux_clock_out, reference_clock_in)
            `CHK(secondary_aux_clock_out, reference_clock_in)
        end
        @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(rowAddr[i]);
            `CHK(v, 8'h00)
        end
        summarize();
    end
endmodule
`default_nettype wire
